// file: rtl/mat_autotune_seq.sv
// Purpose: Autotune test sequencer with inhibit and gain-set select
// Assumes: Measurement and speed flags come from logic on ref_clk
// Notes: Enable and run pins are synchronised before use
//
// Functional notes
// - Selector codes: 1 stationary, 2 rotating, 3 mechanical load.
// - Test starts only with a selection, enable and run all present.
// - Stationary test ends by writing the current-loop gains.
// - Rotating test runs stationary first, then 2/3 frequency held 40 s max.
// - Rotating test writes stator inductance, breakpoints, display power factor.
// - Load test steps torque 20 % to 100 %, aiming at 3/4 speed.
// - Each step below 100 % gets 5 s to reach speed, else next higher step.
// - At 100 % torque allow 60 s, then raise the tuning trip.
// - Non-zero test level runs only that level (6 and 7 run as 5) with 60 s allowed.
// - Each attempt accelerates in the asked direction, then decelerates to zero; a failed last attempt trips instead.
// - After any test, inhibit (or tuning trip if the load test fails) until a controlled disable is seen.
// - Disable sources: enable pin removed, drive enable 0, control word.
// - Gain-set selector 0 picks the first set, 1 the second.
// - Gain-set selector may change at any time.
`timescale 1ns/100ps
`default_nettype none
module mat_autotune_seq #(
    parameter logic [31:0] ROT_HOLD_CYC = 32'(mat_pkg::ROT_HOLD_S * mat_pkg::CLK_HZ),
    parameter logic [31:0] LOAD_STEP_CYC = 32'(mat_pkg::LOAD_STEP_S * mat_pkg::CLK_HZ),
    parameter logic [31:0] LOAD_LAST_CYC = 32'(mat_pkg::LOAD_LAST_S * mat_pkg::CLK_HZ)
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic enable_pin,
    input wire logic run_fwd_pin,
    input wire logic run_rev_pin,
    input wire logic ctrl_word_disable,
    input wire logic stat_meas_done,
    input wire logic rot_meas_done,
    input wire logic speed_reached,
    input wire logic speed_zero,
    output logic drive_run,
    output logic dir_rev,
    output logic accel_cmd,
    output logic [1:0] speed_target,
    output logic [6:0] torque_pct,
    output logic cur_gain_wr,
    output logic rot_param_wr,
    output logic inertia_wr,
    output logic tune_trip,
    output logic inhibit,
    output logic gain_set_sel
);
    typedef struct packed {
        mat_pkg::mat_state_e st;
        logic [1:0] test;
        logic [2:0] step;
        logic fixed;
        logic retry;
        logic dir_rev;
        logic en_s1;
        logic en_s2;
        logic rf_s1;
        logic rf_s2;
        logic rr_s1;
        logic rr_s2;
        logic [1:0] sel;
        logic [2:0] level;
        logic gain_sel;
        logic drv_en;
        logic [mat_pkg::IRQ_W-1:0] irq_st;
        logic [mat_pkg::IRQ_W-1:0] irq_en;
        logic irq;
        logic [31:0] rdata;
        logic drive_run;
        logic accel;
        logic [1:0] target;
        logic [6:0] torque;
        logic cur_gain_wr;
        logic rot_wr;
        logic inertia_wr;
        logic tune_trip;
        logic inhibit;
    } mat_core_s;

    mat_core_s s;
    mat_core_s n;
    logic tmr_go;
    logic tmr_exp;
    logic [31:0] tmr_limit;
    logic run_s;
    logic dis_now;
    logic start_ok;
    logic last;
    logic active;
    logic wr_gain;
    logic [mat_pkg::IRQ_W-1:0] ev;

    // ==========================================================
    // Qualifiers
    assign run_s = s.rf_s2 | s.rr_s2;
    assign dis_now = !s.en_s2 || !s.drv_en || ctrl_word_disable;
    assign start_ok = (s.sel != mat_pkg::SEL_NONE) && s.en_s2 && run_s && !dis_now;
    assign last = s.fixed || (s.step == mat_pkg::STEP_MAX);
    assign active = (s.st != mat_pkg::ST_IDLE) && (s.st != mat_pkg::ST_INHIBIT)
        && (s.st != mat_pkg::ST_TRIP);
    assign wr_gain = reg_wdata[mat_pkg::CTRL_GAIN_BIT];
    // Fixed level always gets the long allowance
    assign tmr_limit = (s.st == mat_pkg::ST_ROT_HOLD) ? ROT_HOLD_CYC :
        (last ? LOAD_LAST_CYC : LOAD_STEP_CYC);

    mat_timer u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(tmr_go),
        .limit(tmr_limit),
        .expired(tmr_exp)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        n = s;
        tmr_go = 1'b0;
        ev = '0;
        n.cur_gain_wr = 1'b0;
        n.rot_wr = 1'b0;
        n.inertia_wr = 1'b0;
        n.rdata = 32'h0000_0000;
        n.en_s1 = enable_pin;
        n.en_s2 = s.en_s1;
        n.rf_s1 = run_fwd_pin;
        n.rf_s2 = s.rf_s1;
        n.rr_s1 = run_rev_pin;
        n.rr_s2 = s.rr_s1;
        unique case (s.st)
            mat_pkg::ST_IDLE:
            begin
                if (start_ok)
                begin
                    n.test = s.sel;
                    n.dir_rev = s.rr_s2 && !s.rf_s2;
                    if (s.sel == mat_pkg::SEL_LOAD)
                    begin
                        n.st = mat_pkg::ST_LOAD_ACC;
                        n.fixed = s.level != 3'h0;
                        n.step = (s.level == 3'h0) ? mat_pkg::STEP_MIN :
                            ((s.level > mat_pkg::STEP_MAX) ? mat_pkg::STEP_MAX : s.level);
                        tmr_go = 1'b1;
                    end
                    else
                        n.st = mat_pkg::ST_STAT;
                end
            end
            mat_pkg::ST_STAT:
            begin
                if (stat_meas_done)
                begin
                    n.cur_gain_wr = 1'b1;
                    if (s.test == mat_pkg::SEL_ROT)
                        n.st = mat_pkg::ST_ROT_ACC;
                    else
                        n.st = mat_pkg::ST_INHIBIT;
                end
            end
            mat_pkg::ST_ROT_ACC:
            begin
                if (speed_reached)
                begin
                    n.st = mat_pkg::ST_ROT_HOLD;
                    tmr_go = 1'b1;
                end
            end
            mat_pkg::ST_ROT_HOLD:
            begin
                if (rot_meas_done || tmr_exp)
                begin
                    n.rot_wr = 1'b1;
                    n.retry = 1'b0;
                    n.st = mat_pkg::ST_DECEL;
                end
            end
            mat_pkg::ST_LOAD_ACC:
            begin
                if (speed_reached)
                begin
                    n.inertia_wr = 1'b1;
                    n.retry = 1'b0;
                    n.st = mat_pkg::ST_DECEL;
                end
                else if (tmr_exp)
                begin
                    if (last)
                        n.st = mat_pkg::ST_TRIP;
                    else
                    begin
                        n.retry = 1'b1;
                        n.st = mat_pkg::ST_DECEL;
                    end
                end
            end
            mat_pkg::ST_DECEL:
            begin
                if (speed_zero)
                begin
                    if (s.retry)
                    begin
                        n.step = s.step + 3'h1;
                        n.st = mat_pkg::ST_LOAD_ACC;
                        ev[mat_pkg::EV_STEP] = 1'b1;
                        tmr_go = 1'b1;
                    end
                    else
                        n.st = mat_pkg::ST_INHIBIT;
                end
            end
            mat_pkg::ST_INHIBIT, mat_pkg::ST_TRIP:
            begin
                // Released only by a controlled disable
                if (dis_now)
                    n.st = mat_pkg::ST_IDLE;
            end
        endcase
        // Losing the enable pin mid-test aborts without inhibit
        if (active && !s.en_s2)
        begin
            n.st = mat_pkg::ST_IDLE;
            tmr_go = 1'b0;
        end
        if (n.st == mat_pkg::ST_INHIBIT && s.st != mat_pkg::ST_INHIBIT)
            ev[mat_pkg::EV_DONE] = 1'b1;
        if (n.st == mat_pkg::ST_TRIP && s.st != mat_pkg::ST_TRIP)
            ev[mat_pkg::EV_TRIP] = 1'b1;
        n.inhibit = n.st == mat_pkg::ST_INHIBIT;
        n.tune_trip = n.st == mat_pkg::ST_TRIP;
        n.drive_run = (n.st != mat_pkg::ST_IDLE) && !n.inhibit && !n.tune_trip;
        n.accel = (n.st == mat_pkg::ST_ROT_ACC) || (n.st == mat_pkg::ST_ROT_HOLD)
            || (n.st == mat_pkg::ST_LOAD_ACC);
        n.target = (n.st == mat_pkg::ST_LOAD_ACC) ? mat_pkg::TGT_SPEED_3_4 :
            ((n.st == mat_pkg::ST_ROT_ACC || n.st == mat_pkg::ST_ROT_HOLD) ?
            mat_pkg::TGT_FREQ_2_3 : mat_pkg::TGT_ZERO);
        n.torque = (n.st == mat_pkg::ST_LOAD_ACC) ? 7'(n.step) * mat_pkg::TRQ_STEP_PCT : 7'h00;
        // Register writes; set beats clear on the status bits
        if (reg_wr && reg_addr == mat_pkg::ADDR_CTRL)
        begin
            n.sel = reg_wdata[mat_pkg::CTRL_SEL_MSB:mat_pkg::CTRL_SEL_LSB];
            n.level = reg_wdata[mat_pkg::CTRL_LVL_MSB:mat_pkg::CTRL_LVL_LSB];
            n.gain_sel = wr_gain;
            n.drv_en = reg_wdata[mat_pkg::CTRL_DRV_EN_BIT];
        end
        if (reg_wr && reg_addr == mat_pkg::ADDR_IRQ_EN)
            n.irq_en = reg_wdata[mat_pkg::IRQ_W-1:0];
        if (reg_wr && reg_addr == mat_pkg::ADDR_IRQ_CLR)
            n.irq_st = s.irq_st & ~reg_wdata[mat_pkg::IRQ_W-1:0];
        n.irq_st = n.irq_st | ev;
        n.irq = |(n.irq_st & n.irq_en);
        if (reg_rd)
        begin
            unique case (reg_addr)
                mat_pkg::ADDR_CTRL:
                begin
                    n.rdata[mat_pkg::CTRL_SEL_MSB:mat_pkg::CTRL_SEL_LSB] = s.sel;
                    n.rdata[mat_pkg::CTRL_LVL_MSB:mat_pkg::CTRL_LVL_LSB] = s.level;
                    n.rdata[mat_pkg::CTRL_GAIN_BIT] = s.gain_sel;
                    n.rdata[mat_pkg::CTRL_DRV_EN_BIT] = s.drv_en;
                end
                mat_pkg::ADDR_STATUS:
                begin
                    n.rdata[mat_pkg::STAT_ST_MSB:mat_pkg::STAT_ST_LSB] = s.st;
                    n.rdata[mat_pkg::STAT_STEP_MSB:mat_pkg::STAT_STEP_LSB] = s.step;
                    n.rdata[mat_pkg::STAT_INH_BIT] = s.inhibit;
                    n.rdata[mat_pkg::STAT_TRIP_BIT] = s.tune_trip;
                    n.rdata[mat_pkg::STAT_EN_BIT] = s.en_s2;
                    n.rdata[mat_pkg::STAT_RUN_BIT] = run_s;
                end
                mat_pkg::ADDR_IRQ_STAT:
                    n.rdata[mat_pkg::IRQ_W-1:0] = s.irq_st;
                mat_pkg::ADDR_IRQ_EN:
                    n.rdata[mat_pkg::IRQ_W-1:0] = s.irq_en;
                default:
                    n.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.st <= mat_pkg::ST_IDLE;
            s.drv_en <= mat_pkg::CTRL_DRV_EN_RST;
        end
        else
            s <= n;
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = s.rdata;
    assign irq = s.irq;
    assign drive_run = s.drive_run;
    assign dir_rev = s.dir_rev;
    assign accel_cmd = s.accel;
    assign speed_target = s.target;
    assign torque_pct = s.torque;
    assign cur_gain_wr = s.cur_gain_wr;
    assign rot_param_wr = s.rot_wr;
    assign inertia_wr = s.inertia_wr;
    assign tune_trip = s.tune_trip;
    assign inhibit = s.inhibit;
    assign gain_set_sel = s.gain_sel;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_start_needs_cmds: assert property (
        s.st == mat_pkg::ST_IDLE ##1 s.st != mat_pkg::ST_IDLE |-> $past(start_ok))
        else $error("test started without selection, enable and run");
    a_load_select_code: assert property (
        s.st == mat_pkg::ST_IDLE && start_ok && s.sel == mat_pkg::SEL_LOAD
        |=> s.st == mat_pkg::ST_LOAD_ACC && s.torque != 7'h00)
        else $error("selector 3 did not start the load test");
    a_stat_gain_write: assert property (
        s.st == mat_pkg::ST_STAT && stat_meas_done && s.en_s2
        |=> s.cur_gain_wr ##1 !s.cur_gain_wr)
        else $error("current-loop gains not written once");
    a_rot_after_stat: assert property (
        s.st == mat_pkg::ST_STAT && stat_meas_done && s.en_s2 && s.test == mat_pkg::SEL_ROT
        |=> s.st == mat_pkg::ST_ROT_ACC && s.target == mat_pkg::TGT_FREQ_2_3)
        else $error("rotating phase did not follow stationary phase");
    a_rot_param_write: assert property (
        s.st == mat_pkg::ST_ROT_HOLD && (rot_meas_done || tmr_exp) && s.en_s2
        |=> s.rot_wr && s.st == mat_pkg::ST_DECEL)
        else $error("rotating results not written");
    a_step_advance: assert property (
        s.st == mat_pkg::ST_DECEL && s.retry && speed_zero && s.en_s2
        |=> s.st == mat_pkg::ST_LOAD_ACC && s.step == $past(s.step) + 3'h1)
        else $error("torque step did not advance by one");
    a_last_step_trip: assert property (
        s.st == mat_pkg::ST_LOAD_ACC && tmr_exp && !speed_reached && last && s.en_s2
        |=> s.tune_trip && !s.drive_run)
        else $error("tuning trip missing after last step");
    a_fixed_level_time: assert property (
        s.st == mat_pkg::ST_LOAD_ACC && s.fixed |-> tmr_limit == LOAD_LAST_CYC)
        else $error("fixed level not given the long allowance");
    a_decel_first: assert property (
        s.st == mat_pkg::ST_LOAD_ACC && tmr_exp && !speed_reached && !last && s.en_s2
        |=> s.st == mat_pkg::ST_DECEL && s.target == mat_pkg::TGT_ZERO && !s.accel)
        else $error("retry without deceleration to zero");
    a_inhibit_hold: assert property (
        s.inhibit && !dis_now |=> s.inhibit)
        else $error("inhibit left without controlled disable");
    a_disable_release: assert property (
        s.st == mat_pkg::ST_INHIBIT && dis_now |=> !s.inhibit && s.st == mat_pkg::ST_IDLE)
        else $error("controlled disable did not release inhibit");
    a_gain_sel_any: assert property (
        reg_wr && reg_addr == mat_pkg::ADDR_CTRL |=> gain_set_sel == $past(wr_gain))
        else $error("gain-set selector write not taken");

    c_rot_done: cover property (s.st == mat_pkg::ST_ROT_HOLD ##[1:1000] s.inhibit);
    c_step_retry: cover property (s.st == mat_pkg::ST_DECEL && s.retry ##1 s.step != 3'h1);
    c_trip: cover property (s.tune_trip ##1 !s.tune_trip);
    c_irq: cover property (irq ##1 !irq);
endmodule
`default_nettype wire

// file: shared/mat_pkg.sv
// Purpose: Constants shared by the autotune sequencer and its bench
// Assumes: 50 MHz ref_clk, 8-bit register address, 32-bit data
// Notes: Times are in seconds; cycle counts derive at the top level
package mat_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    // ==========================================================
    // Control fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_SEL_MSB = 1;
    localparam int CTRL_LVL_LSB = 2;
    localparam int CTRL_LVL_MSB = 4;
    localparam int CTRL_GAIN_BIT = 5;
    localparam int CTRL_DRV_EN_BIT = 6;
    localparam logic CTRL_DRV_EN_RST = 1'h1;
    // ==========================================================
    // Status fields
    localparam int STAT_ST_LSB = 0;
    localparam int STAT_ST_MSB = 2;
    localparam int STAT_STEP_LSB = 3;
    localparam int STAT_STEP_MSB = 5;
    localparam int STAT_INH_BIT = 6;
    localparam int STAT_TRIP_BIT = 7;
    localparam int STAT_EN_BIT = 8;
    localparam int STAT_RUN_BIT = 9;
    // ==========================================================
    // Interrupt events
    localparam int IRQ_W = 3;
    localparam int EV_DONE = 0;
    localparam int EV_TRIP = 1;
    localparam int EV_STEP = 2;
    // ==========================================================
    // Autotune selector codes
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_STAT = 2'h1;
    localparam logic [1:0] SEL_ROT = 2'h2;
    localparam logic [1:0] SEL_LOAD = 2'h3;
    // ==========================================================
    // Speed targets and torque steps
    localparam logic [1:0] TGT_ZERO = 2'h0;
    localparam logic [1:0] TGT_FREQ_2_3 = 2'h1;
    localparam logic [1:0] TGT_SPEED_3_4 = 2'h2;
    localparam logic [2:0] STEP_MIN = 3'h1;
    localparam logic [2:0] STEP_MAX = 3'h5;
    localparam logic [6:0] TRQ_STEP_PCT = 7'h14;
    // ==========================================================
    // Timing
    localparam longint unsigned CLK_HZ = 50_000_000;
    localparam longint unsigned ROT_HOLD_S = 40;
    localparam longint unsigned LOAD_STEP_S = 5;
    localparam longint unsigned LOAD_LAST_S = 60;
    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_STAT, ST_ROT_ACC, ST_ROT_HOLD,
        ST_LOAD_ACC, ST_DECEL, ST_INHIBIT, ST_TRIP
    } mat_state_e;
endpackage

// file: rtl/mat_timer.sv
// Purpose: Time-out counter for the autotune phases
// Assumes: start is a one-cycle pulse; limit stays stable while running
// Notes: expired holds until the next start
`timescale 1ns/100ps
`default_nettype none
module mat_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [31:0] limit,
    output logic expired
);
    typedef struct packed {
        logic [31:0] cnt;
        logic run;
        logic exp;
    } mat_tmr_s;

    mat_tmr_s s;
    mat_tmr_s n;

    // ==========================================================
    // Count
    always_comb
    begin
        n = s;
        if (start)
        begin
            n.cnt = 32'h0000_0000;
            n.run = 1'b1;
            n.exp = 1'b0;
        end
        else if (s.run)
        begin
            n.cnt = s.cnt + 32'h0000_0001;
            // Expires after exactly limit cycles
            if (n.cnt >= limit)
            begin
                n.run = 1'b0;
                n.exp = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            s <= '0;
        else
            s <= n;
    end

    assign expired = s.exp;
endmodule
`default_nettype wire

// file: bench/mat_motor_model.sv
// Purpose: Motor and measurement stand-in for the sequencer
// Assumes: One ref_clk domain, outputs change after the edge
// Notes: slow keeps the shaft still, so every step times out
`timescale 1ns/100ps
`default_nettype none
module mat_motor_model (
    input wire logic ref_clk,
    input wire logic drive_run,
    input wire logic accel_cmd,
    input wire logic [1:0] speed_target,
    input wire logic [6:0] torque_pct,
    input wire logic slow,
    output logic stat_meas_done,
    output logic rot_meas_done,
    output logic speed_reached,
    output logic speed_zero
);
    int spd = 0;
    int run_cnt = 0;
    int hold = 0;
    // ====================================
    // Shaft speed
    // Starts at standstill
    assign speed_zero = (spd == 0);
    assign speed_reached = (spd == 8) && (speed_target != 2'h0);
    always @(posedge ref_clk)
    begin
        // Free shaft accelerates; slow stalls it
        if (drive_run && accel_cmd && speed_target != 2'h0 && !slow)
            spd <= (spd < 8) ? spd + 1 : 8;
        else if (!accel_cmd || !drive_run)
            spd <= (spd > 0) ? spd - 1 : 0;
        run_cnt <= drive_run ? run_cnt + 1 : 0;
        hold <= (speed_target == 2'h1 && spd == 8) ? hold + 1 : 0;
    end
    // ====================================
    // Measurements
    // Standstill measurement, once a run
    assign stat_meas_done = (run_cnt == 6) && (speed_target == 2'h0) && (torque_pct == 7'h00);
    // Ends well inside the hold time-out
    assign rot_meas_done = (hold == 4);
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the autotune sequencer
// Assumes: Shortened time-outs of 40, 12 and 60 cycles
// Notes: Row loop runs each test kind, hand tests follow
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct {
        logic [1:0] sel;
        logic [2:0] lvl;
        logic slw;
        logic rv;
        logic [2:0] ev;
        logic [2:0] wr;
        logic [6:0] trq;
    } mat_row_s;
    logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic enable_pin = 1'b0, run_fwd_pin = 1'b0, run_rev_pin = 1'b0;
    logic ctrl_word_disable = 1'b0, slow = 1'b0;
    logic stat_meas_done, rot_meas_done, speed_reached, speed_zero;
    logic irq, drive_run, dir_rev, accel_cmd, cur_gain_wr, rot_param_wr;
    logic inertia_wr, tune_trip, inhibit, gain_set_sel, rev_seen = 1'b0;
    logic [1:0] speed_target;
    logic [6:0] torque_pct, max_trq = 7'h00;
    logic [2:0] seen = 3'h0;
    int err_count = 0;
    int samples_checked = 0;
    // Every selector code; stationary writes no power factor
    mat_row_s rows [5] = '{'{2'h1, 3'h0, 0, 0, 3'h1, 3'h1, 7'h00},
        '{2'h2, 3'h0, 0, 0, 3'h1, 3'h3, 7'h00}, '{2'h3, 3'h0, 0, 1, 3'h1, 3'h4, 7'h14},
        '{2'h3, 3'h0, 1, 0, 3'h6, 3'h0, 7'h64}, '{2'h3, 3'h2, 1, 0, 3'h2, 3'h0, 7'h28}};
    always #10 ref_clk = ~ref_clk;
    mat_autotune_seq #(.ROT_HOLD_CYC(32'h28), .LOAD_STEP_CYC(32'hC),
        .LOAD_LAST_CYC(32'h3C)) i_mat_autotune_seq (.ref_clk, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .enable_pin, .run_fwd_pin,
        .run_rev_pin, .ctrl_word_disable, .stat_meas_done, .rot_meas_done,
        .speed_reached, .speed_zero, .drive_run, .dir_rev, .accel_cmd, .speed_target,
        .torque_pct, .cur_gain_wr, .rot_param_wr, .inertia_wr, .tune_trip, .inhibit,
        .gain_set_sel);
    mat_motor_model i_mat_motor_model (.ref_clk, .drive_run, .accel_cmd,
        .speed_target, .torque_pct, .slow, .stat_meas_done, .rot_meas_done,
        .speed_reached, .speed_zero);
    // ====================================
    // Monitor of pulses, torque and direction
    always @(posedge ref_clk)
    begin
        seen <= reg_wr ? 3'h0 : seen | {inertia_wr, rot_param_wr, cur_gain_wr};
        max_trq <= reg_wr ? 7'h00 : ((torque_pct > max_trq) ? torque_pct : max_trq);
        if (drive_run)
            rev_seen <= dir_rev;
    end
    // ====================================
    // Bus tasks and checks
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        cyc(20000);
        err_count++;
        report_and_stop();
    end
    // ====================================
    // Main sequence
    initial
    begin
        logic [31:0] d;
        int k;
        cyc(4);
        rst <= 1'b0;
        enable_pin <= 1'b1;
        rd(mat_pkg::ADDR_CTRL, d);
        chk("ctrl reset", 32'h40, d);
        rd(8'h20, d);
        chk("unmapped read", 32'h0, d);
        wr(mat_pkg::ADDR_IRQ_EN, 32'h7);
        foreach (rows[i])
        begin
            wr(mat_pkg::ADDR_CTRL, {25'h0, 2'h2, rows[i].lvl, rows[i].sel});
            slow <= rows[i].slw;
            @(posedge ref_clk);
            run_fwd_pin <= !rows[i].rv;
            run_rev_pin <= rows[i].rv;
            k = 0;
            while (k < 600 && inhibit !== 1'b1 && tune_trip !== 1'b1)
            begin
                @(posedge ref_clk);
                #1 k++;
            end
            cyc(10);
            #1 chk("inhibit", {31'h0, rows[i].ev[0]}, {31'h0, inhibit});
            chk("trip", {31'h0, rows[i].ev[1]}, {31'h0, tune_trip});
            chk("run after test", 32'h0, {31'h0, drive_run});
            chk("writes", {29'h0, rows[i].wr}, {29'h0, seen});
            chk("top torque", {25'h0, rows[i].trq}, {25'h0, max_trq});
            chk("direction", {31'h0, rows[i].rv}, {31'h0, rev_seen});
            chk("irq", 32'h1, {31'h0, irq});
            rd(mat_pkg::ADDR_IRQ_STAT, d);
            chk("irq status", {29'h0, rows[i].ev}, d);
            wr(mat_pkg::ADDR_IRQ_CLR, 32'h7);
            cyc(2);
            #1 chk("irq cleared", 32'h0, {31'h0, irq});
            @(posedge ref_clk);
            run_fwd_pin <= 1'b0;
            run_rev_pin <= 1'b0;
            case (i % 3)
                0: enable_pin <= 1'b0;
                1: wr(mat_pkg::ADDR_CTRL, 32'h0);
                default: ctrl_word_disable <= 1'b1;
            endcase
            cyc(5);
            #1 chk("released", 32'h0, {30'h0, inhibit, tune_trip});
            @(posedge ref_clk);
            enable_pin <= 1'b1;
            ctrl_word_disable <= 1'b0;
            cyc(4);
            $display("test %0d done", i);
        end
        // Abort by enable loss mid-test, no inhibit left behind
        wr(mat_pkg::ADDR_CTRL, 32'h43);
        slow <= 1'b1;
        run_fwd_pin <= 1'b1;
        cyc(8);
        enable_pin <= 1'b0;
        cyc(5);
        #1 chk("abort run", 32'h0, {31'h0, drive_run});
        chk("abort inhibit", 32'h0, {31'h0, inhibit});
        @(posedge ref_clk);
        run_fwd_pin <= 1'b0;
        enable_pin <= 1'b1;
        $display("test abort done");
        // Gain set flips while enabled; run with no selection is ignored
        wr(mat_pkg::ADDR_CTRL, 32'h60);
        run_fwd_pin <= 1'b1;
        cyc(8);
        #1 chk("gain set", 32'h1, {31'h0, gain_set_sel});
        chk("no selection", 32'h0, {31'h0, drive_run});
        rd(mat_pkg::ADDR_CTRL, d);
        chk("ctrl readback", 32'h60, d);
        $display("test gain done");
        // Second reset with run pin held and no test running restores defaults
        @(posedge ref_clk);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        #1 chk("gain after reset", 32'h0, {31'h0, gain_set_sel});
        rd(mat_pkg::ADDR_CTRL, d);
        chk("ctrl after reset", 32'h40, d);
        rd(mat_pkg::ADDR_STATUS, d);
        chk("status after reset", 32'h300, d);
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
